// ===== core/pmi_cmd_bank.sv
// Command bank for input power, revision, identity, version and text strings
// Behaviour
// - Input power reads as two-byte Linear-11 word
// - Revision byte reads 33h, one nibble per part
// - Six maker strings, block read/write, 32 bytes
// - Two user strings, block read/write, 32 bytes
// - Text bytes plus overhead never exceed 128
// - Every write before commit charges the budget, except one ending in a reload's recount cycle
// - Identity block: maker, high, low, reserved
// - Version block: interface then firmware, major, minor
`timescale 1ns/1ns
`default_nettype none
module pmi_cmd_bank
    import pmi_pkg::*;
#(
    parameter int         N_TEXT    = TEXT_COUNT,
    parameter int         TEXT_LEN  = TEXT_MAX,
    parameter logic [7:0] ID_MAKER  = 8'h5a,  // Arbitrary value
    parameter logic [7:0] ID_HIGH   = 8'h12,  // Arbitrary value
    parameter logic [7:0] ID_LOW    = 8'h34,  // Arbitrary value
    parameter logic [7:0] IF_MAJOR  = 8'h01,  // Arbitrary value
    parameter logic [7:0] IF_MINOR  = 8'h00,  // Arbitrary value
    parameter logic [7:0] FW_MAJOR  = 8'h02,  // Arbitrary value
    parameter logic [7:0] FW_MINOR  = 8'h03   // Arbitrary value
)(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Decoded command link
    input  wire pmi_cmd_t    cmd,
    input  wire pmi_byte_t   wr_byte,
    input  wire logic        rd_pull,
    // Answers
    output pmi_byte_t        rd,
    output logic             wr_done,
    output logic             cmd_refused,
    // Measurement
    input  wire logic [15:0] pin_watts,
    // Nonvolatile commit and reload
    input  wire logic        nvm_store,
    input  wire logic        nvm_restore,
    output logic             nvm_busy,
    // Budget
    input  wire logic [7:0]  ext_bytes,
    output logic      [7:0]  budget_used
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pmi_state_t       state_q;
    logic [7:0]       code_q;
    logic [SEL_W-1:0] sel_q;
    logic             hit_q;
    logic [5:0]       pos_q;
    logic [5:0]       cnt_q;
    logic [5:0]       rcv_q;
    logic [7:0]       used_q;
    pmi_byte_t        rd_q;
    logic             done_q;
    logic             refused_q;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    wire logic             hit_c;
    wire logic [SEL_W-1:0] sel_c;
    wire logic             ro_c;
    wire logic             known_c;
    assign hit_c   = (cmd.code >= CMD_MAKER && cmd.code <= CMD_SERIAL) ||
                     cmd.code == CMD_USER0 || cmd.code == CMD_USER1;
    assign sel_c   = (cmd.code == CMD_USER0) ? TXT_USER0 :
                     (cmd.code == CMD_USER1) ? TXT_USER1 :
                     SEL_W'(cmd.code - CMD_MAKER);
    assign ro_c    = cmd.code == CMD_PIN || cmd.code == CMD_REV ||
                     cmd.code == CMD_SIL_ID || cmd.code == CMD_SIL_VER;
    assign known_c = hit_c || ro_c;

    // ------------------------------------------------------------------
    // Budget check on the count byte
    // ------------------------------------------------------------------
    wire logic [8:0] limit_c;
    wire logic [8:0] need_c;
    wire logic       too_long_c;
    wire logic       fits_c;
    wire logic       nvm_done;
    wire logic [7:0] nvm_total;
    // Bytes held by text commands outside this bank shrink the room here
    assign limit_c    = (ext_bytes > BUDGET_MAX) ? 9'h000 : {1'b0, BUDGET_MAX - ext_bytes};
    assign need_c     = {1'b0, used_q} + {1'b0, wr_byte.data} + {1'b0, OVERHEAD};
    assign too_long_c = wr_byte.data > TEXT_MAX8;
    assign fits_c     = !too_long_c && need_c <= limit_c;

    // ------------------------------------------------------------------
    // Store control
    // ------------------------------------------------------------------
    wire logic             st_wr_en;
    wire logic             st_len_we;
    wire logic [IDX_W-1:0] st_rd_idx;
    wire logic [7:0]       st_rd_byte;
    wire logic [LEN_W-1:0] st_rd_len;
    wire logic             rd_take;
    // Bytes past the announced count are dropped, never stored
    assign st_wr_en  = state_q == ST_WDATA && wr_byte.valid && rcv_q < cnt_q;
    assign st_len_we = state_q == ST_WDATA && cmd.stop && !cmd.start;
    assign st_rd_idx = IDX_W'(pos_q - 6'h01);
    assign rd_take   = rd_pull && state_q == ST_READ;

    pmi_text_store #(
        .N      (N_TEXT),
        .MAXLEN (TEXT_LEN)
    ) u_store (
        .mclk         (mclk),
        .srst         (srst),
        .wr_en        (st_wr_en),
        .wr_sel       (sel_q),
        .wr_idx       (IDX_W'(rcv_q)),
        .wr_data      (wr_byte.data),
        .len_we       (st_len_we),
        .len_val      (rcv_q),
        .rd_sel       (sel_q),
        .rd_idx       (st_rd_idx),
        .rd_byte      (st_rd_byte),
        .rd_len       (st_rd_len),
        .store_req    (nvm_store),
        .restore_req  (nvm_restore),
        .busy         (nvm_busy),
        .restore_done (nvm_done),
        .nvm_total    (nvm_total)
    );

    // ------------------------------------------------------------------
    // Read byte selection, position 0 first
    // ------------------------------------------------------------------
    wire logic [7:0] pin_byte_c;
    wire logic [7:0] id_byte_c;
    wire logic [7:0] ver_byte_c;
    wire logic [7:0] txt_byte_c;
    wire logic [7:0] rd_next_c;
    // Word goes out low byte first, as the link sends words
    assign pin_byte_c = (pos_q == 6'h00) ? pin_watts[7:0] :
                        (pos_q == 6'h01) ? pin_watts[15:8] : PAD_BYTE;
    assign id_byte_c  = (pos_q == 6'h00) ? SIL_COUNT :
                        (pos_q == 6'h01) ? ID_MAKER :
                        (pos_q == 6'h02) ? ID_HIGH :
                        (pos_q == 6'h03) ? ID_LOW :
                        (pos_q == 6'h04) ? ID_RSVD : PAD_BYTE;
    assign ver_byte_c = (pos_q == 6'h00) ? SIL_COUNT :
                        (pos_q == 6'h01) ? IF_MAJOR :
                        (pos_q == 6'h02) ? IF_MINOR :
                        (pos_q == 6'h03) ? FW_MAJOR :
                        (pos_q == 6'h04) ? FW_MINOR : PAD_BYTE;
    assign txt_byte_c = (pos_q == 6'h00) ? 8'(st_rd_len) :
                        (pos_q <= st_rd_len) ? st_rd_byte : PAD_BYTE;
    assign rd_next_c  = hit_q ? txt_byte_c :
                        (code_q == CMD_PIN) ? pin_byte_c :
                        (code_q == CMD_REV && pos_q == 6'h00) ? REV_RESET :
                        (code_q == CMD_SIL_ID) ? id_byte_c :
                        (code_q == CMD_SIL_VER) ? ver_byte_c : PAD_BYTE;

    // ------------------------------------------------------------------
    // Transaction sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        done_q    <= 1'b0;
        refused_q <= 1'b0;
        if (srst) begin
            state_q <= ST_IDLE;
            code_q  <= 8'h00;
            sel_q   <= '0;
            hit_q   <= 1'b0;
            pos_q   <= 6'h00;
            cnt_q   <= 6'h00;
            rcv_q   <= 6'h00;
        end else if (cmd.start) begin
            code_q <= cmd.code;
            sel_q  <= sel_c;
            hit_q  <= hit_c;
            pos_q  <= 6'h00;
            rcv_q  <= 6'h00;
            if (!cmd.wr) begin
                state_q   <= ST_READ;
                refused_q <= !known_c;
            end else if (hit_c && !nvm_busy) begin
                state_q <= ST_WCOUNT;
            end else begin
                // Read-only, unknown, or store busy: swallow the payload
                state_q   <= ST_WDROP;
                refused_q <= 1'b1;
            end
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                end
                ST_WCOUNT: begin
                    if (cmd.stop) begin
                        state_q <= ST_IDLE;
                    end else if (wr_byte.valid) begin
                        cnt_q     <= wr_byte.data[5:0];
                        state_q   <= fits_c ? ST_WDATA : ST_WDROP;
                        refused_q <= !fits_c;
                    end
                end
                ST_WDATA: begin
                    if (cmd.stop) begin
                        state_q <= ST_IDLE;
                        done_q  <= 1'b1;
                    end else if (st_wr_en) begin
                        rcv_q <= rcv_q + 6'h01;
                    end
                end
                ST_WDROP, ST_READ: begin
                    if (cmd.stop) begin
                        state_q <= ST_IDLE;
                    end
                    if (rd_take && pos_q != POS_MAX) begin
                        pos_q <= pos_q + 6'h01;
                    end
                end
            endcase
        end
    end

    // Budget: a reload recounts what was committed, a write adds its bytes
    always_ff @(posedge mclk) begin
        if (srst) begin
            used_q <= 8'h00;
        end else if (nvm_done) begin
            used_q <= nvm_total;
        end else if (st_len_we) begin
            used_q <= used_q + 8'(rcv_q) + OVERHEAD;
        end
    end

    // Answer byte register; a pull outside a read gets no answer
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_q <= '0;
        end else begin
            rd_q.valid <= rd_take;
            if (rd_take) begin
                rd_q.data <= rd_next_c;
            end
        end
    end

    assign rd          = rd_q;
    assign wr_done     = done_q;
    assign cmd_refused = refused_q;
    assign budget_used = used_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    property p_pin_word;
        rd_take && !cmd.start && code_q == CMD_PIN && pos_q == 6'h00 ##1
        rd_take && !cmd.start && pos_q == 6'h01 && $stable(pin_watts)
        |=> rd.valid && {rd.data, $past(rd.data)} == $past(pin_watts);
    endproperty
    a_pin_word: assert property (p_pin_word)
        else $error("input power word not returned low byte first");

    property p_rev;
        rd_take && code_q == CMD_REV && pos_q == 6'h00 |=> rd.valid && rd.data == REV_RESET;
    endproperty
    a_rev: assert property (p_rev)
        else $error("revision byte wrong");

    property p_maker_long;
        state_q == ST_WCOUNT && !cmd.start && !cmd.stop && wr_byte.valid &&
        sel_q < TXT_USER0 && wr_byte.data > TEXT_MAX8
        |=> cmd_refused && state_q == ST_WDROP ##1 !wr_done;
    endproperty
    a_maker_long: assert property (p_maker_long)
        else $error("maker string over 32 bytes accepted");

    property p_user_long;
        state_q == ST_WCOUNT && !cmd.start && !cmd.stop && wr_byte.valid &&
        sel_q >= TXT_USER0 && wr_byte.data > TEXT_MAX8
        |=> cmd_refused && $stable(budget_used);
    endproperty
    a_user_long: assert property (p_user_long)
        else $error("user string over 32 bytes accepted");

    property p_budget;
        budget_used <= BUDGET_MAX;
    endproperty
    a_budget: assert property (p_budget)
        else $error("text budget exceeded");

    property p_charge;
        wr_done && !$past(nvm_done) |-> budget_used == $past(budget_used) + 8'($past(rcv_q)) + OVERHEAD;
    endproperty
    a_charge: assert property (p_charge)
        else $error("write not charged to budget");

    property p_id_block;
        rd_take && !cmd.start && code_q == CMD_SIL_ID && pos_q == 6'h00 ##1
        rd_take && !cmd.start |=> rd.data == ID_MAKER && $past(rd.data) == SIL_COUNT;
    endproperty
    a_id_block: assert property (p_id_block)
        else $error("identity block count or maker byte wrong");

    property p_ver_block;
        rd_take && code_q == CMD_SIL_VER && pos_q == 6'h03 |=> rd.valid && rd.data == FW_MAJOR;
    endproperty
    a_ver_block: assert property (p_ver_block)
        else $error("firmware major byte wrong");

    property p_txt_count;
        rd_take && hit_q && pos_q == 6'h00 |=> rd.data == 8'($past(st_rd_len));
    endproperty
    a_txt_count: assert property (p_txt_count)
        else $error("text count byte differs from stored length");

    c_write_ok:   cover property (wr_done);
    c_refused:    cover property (cmd_refused && hit_q);
    c_restore:    cover property (nvm_done);
    c_text_read:  cover property (rd_take && hit_q && pos_q == 6'h01);
endmodule
`default_nettype wire

// ===== core/pmi_pkg.sv
// Shared constants and carriers for the identity and text command block
package pmi_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_PIN     = 8'h97;
    localparam logic [7:0] CMD_REV     = 8'h98;
    localparam logic [7:0] CMD_MAKER   = 8'h99;
    localparam logic [7:0] CMD_MODEL   = 8'h9a;
    localparam logic [7:0] CMD_VERSION = 8'h9b;
    localparam logic [7:0] CMD_SITE    = 8'h9c;
    localparam logic [7:0] CMD_DATE    = 8'h9d;
    localparam logic [7:0] CMD_SERIAL  = 8'h9e;
    localparam logic [7:0] CMD_SIL_ID  = 8'had;
    localparam logic [7:0] CMD_SIL_VER = 8'hae;
    localparam logic [7:0] CMD_USER0   = 8'hb0;
    localparam logic [7:0] CMD_USER1   = 8'hb1;

    // ------------------------------------------------------------------
    // Text slots, sizes and budget
    // ------------------------------------------------------------------
    localparam int         TEXT_COUNT = 8;
    localparam int         TEXT_MAX   = 32;
    localparam int         SEL_W      = 3;
    localparam int         IDX_W      = 5;
    localparam int         LEN_W      = 6;
    localparam logic [2:0] TXT_USER0  = 3'h6;
    localparam logic [2:0] TXT_USER1  = 3'h7;
    localparam logic [7:0] TEXT_MAX8  = 8'h20;
    localparam logic [7:0] BUDGET_MAX = 8'h80;
    localparam logic [7:0] OVERHEAD   = 8'h01;

    // ------------------------------------------------------------------
    // Fixed read values
    // ------------------------------------------------------------------
    localparam logic [7:0] REV_RESET  = 8'h33;  // Part 1 in 7:4, part 2 in 3:0
    localparam logic [7:0] SIL_COUNT  = 8'h04;
    localparam logic [7:0] ID_RSVD    = 8'h00;
    localparam logic [7:0] PAD_BYTE   = 8'hff;
    localparam logic [5:0] POS_MAX    = 6'h3f;

    // ------------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       start;
        logic       wr;
        logic       stop;
        logic [7:0] code;
    } pmi_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } pmi_byte_t;

    typedef enum logic [2:0] {ST_IDLE, ST_WCOUNT, ST_WDATA, ST_WDROP, ST_READ} pmi_state_t;
    typedef enum logic [1:0] {CP_IDLE, CP_STORE, CP_RESTORE} pmi_copy_t;

endpackage

// ===== core/pmi_text_store.sv
// Live and committed text storage with a byte-serial store and restore copier
`timescale 1ns/1ns
`default_nettype none
module pmi_text_store
    import pmi_pkg::*;
#(
    parameter int N      = TEXT_COUNT,
    parameter int MAXLEN = TEXT_MAX
)(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Host byte writes into the live copy
    input  wire logic             wr_en,
    input  wire logic [SEL_W-1:0] wr_sel,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [7:0]       wr_data,
    input  wire logic             len_we,
    input  wire logic [LEN_W-1:0] len_val,
    // Reads from the live copy
    input  wire logic [SEL_W-1:0] rd_sel,
    input  wire logic [IDX_W-1:0] rd_idx,
    output logic      [7:0]       rd_byte,
    output logic      [LEN_W-1:0] rd_len,
    // Commit and reload
    input  wire logic             store_req,
    input  wire logic             restore_req,
    output logic                  busy,
    output logic                  restore_done,
    output logic      [7:0]       nvm_total
);
    localparam int         AW   = SEL_W + IDX_W;
    localparam logic [AW-1:0] LAST = AW'(N * MAXLEN - 1);

    logic [7:0]       live_q [N*MAXLEN];
    logic [7:0]       nvm_q  [N*MAXLEN];
    logic [LEN_W-1:0] live_len_q [N];
    logic [LEN_W-1:0] nvm_len_q  [N];
    pmi_copy_t        cp_q;
    logic [AW-1:0]    cp_addr_q;
    logic             done_q;
    logic [7:0]       total_c;

    // ------------------------------------------------------------------
    // Reads and status
    // ------------------------------------------------------------------
    assign rd_byte      = live_q[{rd_sel, rd_idx}];
    assign rd_len       = live_len_q[rd_sel];
    assign busy         = (cp_q != CP_IDLE);
    assign restore_done = done_q;
    assign nvm_total    = total_c;

    // Committed bytes with one overhead byte per non-empty string
    always_comb begin
        total_c = 8'h00;
        for (int i = 0; i < N; i++) begin
            if (nvm_len_q[i] != '0) begin
                total_c = total_c + 8'(nvm_len_q[i]) + OVERHEAD;
            end
        end
    end

    // Byte arrays carry no reset; the lengths alone say what is valid
    always_ff @(posedge mclk) begin
        if (cp_q == CP_RESTORE) begin
            live_q[cp_addr_q] <= nvm_q[cp_addr_q];
        end else if (wr_en) begin
            live_q[{wr_sel, wr_idx}] <= wr_data;
        end
        if (cp_q == CP_STORE) begin
            nvm_q[cp_addr_q] <= live_q[cp_addr_q];
        end
    end

    // Copier sequencing; a restore overrides any length written meanwhile
    always_ff @(posedge mclk) begin
        done_q <= 1'b0;
        if (srst) begin
            cp_q      <= CP_IDLE;
            cp_addr_q <= '0;
            for (int i = 0; i < N; i++) begin
                live_len_q[i] <= '0;
                nvm_len_q[i]  <= '0;
            end
        end else begin
            if (len_we) begin
                live_len_q[wr_sel] <= len_val;
            end
            unique case (cp_q)
                CP_IDLE: begin
                    cp_addr_q <= '0;
                    if (store_req) begin
                        cp_q <= CP_STORE;
                    end else if (restore_req) begin
                        cp_q <= CP_RESTORE;
                    end
                end
                CP_STORE, CP_RESTORE: begin
                    cp_addr_q <= cp_addr_q + 1'b1;
                    if (cp_addr_q == LAST) begin
                        cp_q <= CP_IDLE;
                        for (int i = 0; i < N; i++) begin
                            if (cp_q == CP_STORE) begin
                                nvm_len_q[i] <= live_len_q[i];
                            end else begin
                                live_len_q[i] <= nvm_len_q[i];
                            end
                        end
                        done_q <= (cp_q == CP_RESTORE);
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tb/pmi_host.sv
// Host model that drives the command link one item at a time
`timescale 1ns/1ns
`default_nettype none
module pmi_host
    import pmi_pkg::*;
(
    // Clock and answers
    input  wire logic      mclk,
    input  wire pmi_byte_t rd,
    input  wire logic      wr_done,
    input  wire logic      cmd_refused,
    // Requests
    output pmi_cmd_t       cmd,
    output pmi_byte_t      wr_byte,
    output logic           rd_pull
);
    int        slow = 0;  // Idle cycles after each item, for a slow host
    pmi_byte_t ans;
    logic      done_seen;
    logic      ref_seen;

    // Quiet link at time zero
    initial begin
        cmd     = '{1'b0, 1'b0, 1'b0, 8'h00};
        wr_byte = '{1'b0, 8'h00};
        rd_pull = 1'b0;
    end

    // Drive for one edge, release, then catch the one-cycle answers
    task automatic item(input pmi_cmd_t c, input pmi_byte_t b, input logic p);
        @(posedge mclk);
        cmd     <= c;
        wr_byte <= b;
        rd_pull <= p;
        @(posedge mclk);
        cmd     <= '{1'b0, 1'b0, 1'b0, ~c.code};  // Released lines toggle
        wr_byte <= '{1'b0, ~b.data};
        rd_pull <= 1'b0;
        #1;
        ans       = rd;
        done_seen = wr_done;
        ref_seen  = cmd_refused;
        repeat (slow) @(posedge mclk);
    endtask

    // Two pulls on consecutive edges; each answer is caught while it stands
    task automatic pull_pair(output pmi_byte_t a0, output pmi_byte_t a1);
        @(posedge mclk);
        rd_pull <= 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        a0 = rd;
        @(posedge mclk);
        rd_pull <= 1'b0;
        #1;
        a1 = rd;
        repeat (slow) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the identity and text command bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import pmi_pkg::*;
    logic        mclk, srst, nvm_store, nvm_restore, rd_pull, wr_done, cmd_refused, nvm_busy;
    logic [15:0] pin_watts;
    logic [7:0]  ext_bytes, budget_used;
    pmi_cmd_t    cmd;
    pmi_byte_t   wr_byte, rd;
    int          err_count = 0;
    int          checks    = 0;
    int          cycles    = 0;
    logic [7:0]  txt [8] = '{CMD_MAKER, CMD_MODEL, CMD_VERSION, CMD_SITE,
                             CMD_DATE, CMD_SERIAL, CMD_USER0, CMD_USER1};

    pmi_cmd_bank uut (.mclk(mclk), .srst(srst), .cmd(cmd), .wr_byte(wr_byte),
        .rd_pull(rd_pull), .rd(rd), .wr_done(wr_done), .cmd_refused(cmd_refused),
        .pin_watts(pin_watts), .nvm_store(nvm_store), .nvm_restore(nvm_restore),
        .nvm_busy(nvm_busy), .ext_bytes(ext_bytes), .budget_used(budget_used));
    pmi_host host (.mclk(mclk), .rd(rd), .wr_done(wr_done), .cmd_refused(cmd_refused),
        .cmd(cmd), .wr_byte(wr_byte), .rd_pull(rd_pull));

    // Clock, 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Hang guard: far above the fewer than two thousand cycles the tests take
    always @(posedge mclk) begin
        cycles++;
        if (cycles >= 20000) begin
            err_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic op(input logic wr, input logic [7:0] code);
        host.item('{1'b1, wr, 1'b0, code}, '{1'b0, 8'h00}, 1'b0);
    endtask
    task automatic put(input logic [7:0] b);
        host.item('{1'b0, 1'b0, 1'b0, 8'h00}, '{1'b1, b}, 1'b0);
    endtask
    task automatic fin();
        host.item('{1'b0, 1'b0, 1'b1, 8'h00}, '{1'b0, 8'h00}, 1'b0);
    endtask
    task automatic pull(input logic [7:0] exp);
        host.item('{1'b0, 1'b0, 1'b0, 8'h00}, '{1'b0, 8'h00}, 1'b1);
        chk("rd_valid", 8'h01, {7'h00, host.ans.valid});
        chk("rd_data", exp, host.ans.data);
    endtask
    // Two pulls on back-to-back edges
    task automatic pull2(input logic [7:0] e0, input logic [7:0] e1);
        pmi_byte_t a0;
        pmi_byte_t a1;
        host.pull_pair(a0, a1);
        chk("rd_valid", 8'h01, {7'h00, a0.valid});
        chk("rd_data", e0, a0.data);
        chk("rd_valid", 8'h01, {7'h00, a1.valid});
        chk("rd_data", e1, a1.data);
    endtask
    // Block write: count byte, chars from c0 upward, stop
    task automatic wtxt(input logic [7:0] code, input int n, input logic [7:0] c0,
                        input logic ok);
        op(1'b1, code);
        put(8'(n));
        chk("count_refused", {7'h00, !ok}, {7'h00, host.ref_seen});
        for (int i = 0; i < n; i++) put(c0 + 8'(i));
        fin();
        chk("wr_done", {7'h00, ok}, {7'h00, host.done_seen});
    endtask
    task automatic rtxt(input logic [7:0] code, input int n, input logic [7:0] c0);
        op(1'b0, code);
        pull(8'(n));
        for (int i = 0; i < n; i++) pull(c0 + 8'(i));
        fin();
    endtask
    // Pulse a commit or reload, then wait out the copy
    task automatic nvm(input logic st);
        int w;
        @(posedge mclk);
        nvm_store   <= st;
        nvm_restore <= !st;
        @(posedge mclk);
        nvm_store   <= 1'b0;
        nvm_restore <= 1'b0;
        #1;
        chk("nvm_busy", 8'h01, {7'h00, nvm_busy});
        w = 0;
        while (nvm_busy !== 1'b0 && w < 300) begin
            @(posedge mclk);
            #1;
            w++;
        end
        @(posedge mclk);  // Recount lands one edge after the copy ends
        #1;
        chk("nvm_idle", 8'h00, {7'h00, nvm_busy});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fixed();
        chk("budget_reset", 8'h00, budget_used);
        foreach (txt[k]) rtxt(txt[k], 0, 8'h00);
        op(1'b0, CMD_PIN);
        pull2(8'ha5, 8'hd3);
        fin();
        op(1'b0, CMD_REV);
        pull(8'h33);
        pull(8'hff);
        fin();
        op(1'b0, CMD_SIL_ID);
        pull2(8'h04, 8'h5a);
        pull(8'h12);
        pull(8'h34);
        pull(8'h00);
        fin();
        op(1'b0, CMD_SIL_VER);
        foreach (txt[k]) if (k < 5) pull(k == 0 ? 8'h04 : k == 1 ? 8'h01 : k == 2 ? 8'h00 : k == 3 ? 8'h02 : 8'h03);
        fin();
        op(1'b1, CMD_REV);
        chk("ro_refused", 8'h01, {7'h00, host.ref_seen});
        fin();
        $display("test fixed done");
    endtask
    task automatic t_text();
        host.slow = 2;
        wtxt(CMD_MAKER, 3, "A", 1'b1);
        rtxt(CMD_MAKER, 3, "A");
        wtxt(CMD_USER1, 32, "a", 1'b1);
        rtxt(CMD_USER1, 32, "a");
        wtxt(CMD_USER0, 33, "0", 1'b0);
        rtxt(CMD_USER0, 0, 8'h00);
        wtxt(CMD_SITE, 33, "x", 1'b0);
        chk("budget", 8'h25, budget_used);
        host.slow = 0;
        $display("test text done");
    endtask
    task automatic t_budget();
        wtxt(CMD_MAKER, 3, "B", 1'b1);
        chk("budget", 8'h29, budget_used);
        @(posedge mclk);
        ext_bytes <= 8'h50;
        wtxt(CMD_SERIAL, 6, "s", 1'b1);
        wtxt(CMD_DATE, 0, 8'h00, 1'b0);
        chk("budget", 8'h30, budget_used);
        $display("test budget done");
    endtask
    task automatic t_restore();
        nvm(1'b0);
        chk("budget", 8'h00, budget_used);
        rtxt(CMD_MAKER, 0, 8'h00);
        @(posedge mclk);
        ext_bytes <= 8'h00;
        wtxt(CMD_MAKER, 3, "C", 1'b1);
        nvm(1'b1);
        nvm(1'b0);
        chk("budget", 8'h04, budget_used);
        rtxt(CMD_MAKER, 3, "C");
        $display("test restore done");
    endtask

    // Main sequence
    initial begin
        srst        = 1'b1;
        nvm_store   = 1'b0;
        nvm_restore = 1'b0;
        pin_watts   = 16'hd3a5;
        ext_bytes   = 8'h00;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_fixed();
        t_text();
        t_budget();
        t_restore();
        conclude();
    end
endmodule
`default_nettype wire
